// >>> rtl/ufird_consts.vh
// constants for the uart fifo, interrupt and dma-ready block
`ifndef UFIRD_CONSTS_VH
`define UFIRD_CONSTS_VH

// ***************************************************
// apb register byte offsets
// ***************************************************
`define UFIRD_OFS_DATA      8'h00
`define UFIRD_OFS_IMASK     8'h04
`define UFIRD_OFS_FCTRL     8'h08
`define UFIRD_OFS_CAUSE     8'h0C
`define UFIRD_OFS_LSTATE    8'h10

// ***************************************************
// interrupt mask fields
// ***************************************************
`define UFIRD_IM_RX_DMA_REQUEST_N      0
`define UFIRD_IM_TXEMPTY    1
`define UFIRD_IM_LSTAT      2
`define UFIRD_IM_MODEM      3
`define UFIRD_IMASK_RST     4'h0

// ***************************************************
// fifo control fields
// ***************************************************
`define UFIRD_FC_ENABLE     0
`define UFIRD_FC_RXRST      1
`define UFIRD_FC_TXRST      2
`define UFIRD_FC_DMAMODE    3
`define UFIRD_FC_THR_LO     6
`define UFIRD_FC_THR_HI     7
`define UFIRD_THR_RST       2'h0

// ***************************************************
// line state fields
// ***************************************************
`define UFIRD_LS_DREADY     0
`define UFIRD_LS_OVERRUN    1
`define UFIRD_LS_TXFEMPTY   5
`define UFIRD_LS_TXALLEMPTY 6
`define UFIRD_LS_FIFOERR    7

// ***************************************************
// fifo sizing and thresholds
// ***************************************************
`define UFIRD_DEPTH         5'h10
`define UFIRD_THR_1         5'h01
`define UFIRD_THR_4         5'h04
`define UFIRD_THR_8         5'h08
`define UFIRD_THR_14        5'h0E

// ***************************************************
// interrupt cause codes
// ***************************************************
`define UFIRD_IC_NONE       8'h01
`define UFIRD_IC_LSTAT      8'h06
`define UFIRD_IC_RXDATA     8'h04
`define UFIRD_IC_RXTOUT     8'h0C
`define UFIRD_IC_TXEMPTY    8'h02

`endif

// >>> rtl/ufird_core.v
// uart fifo, interrupt enable and dma ready logic behind an apb slave
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "ufird_consts.vh"

// ***************************************************
// ***************************************************

module ufird_core
(
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // characters from the receive shift register
   input  wire        rx_char_valid,
   input  wire [7:0]  rx_char_data,
   input  wire        rx_char_parity_err,
   input  wire        rx_char_frame_err,
   input  wire        rx_char_break,
   input  wire        rx_timeout,
   // characters to the transmit shift register
   output wire        tx_char_valid,
   output wire [7:0]  tx_char_data,
   input  wire        tx_char_ready,
   input  wire        tx_shift_busy,
   // interrupt and dma ready pins
   output reg         irq_ff,
   output reg         tx_dma_request_n,
   output reg         rx_dma_request_n
);

   // ***************************************************
   // helper functions
   // ***************************************************

   // threshold code to byte count
   function [4:0] thr_bytes;
      input [1:0] code;
      begin
         case (code)
            2'h0:    thr_bytes = `UFIRD_THR_1;
            2'h1:    thr_bytes = `UFIRD_THR_4;
            2'h2:    thr_bytes = `UFIRD_THR_8;
            default: thr_bytes = `UFIRD_THR_14;
         endcase
      end
   endfunction

   // pointer wrap, also used to collapse to one slot when fifos are off
   function [3:0] ptr_inc;
      input [3:0] p;
      input       fifo_on;
      begin
         ptr_inc = fifo_on ? p + 4'h1 : 4'h0;
      end
   endfunction

   // ***************************************************
   // state
   // ***************************************************
   reg  [3:0]  imask_ff;        // interrupt_mask_reg bits 3..0
   reg         fifo_en_ff;      // fifo enable
   reg         dma_mode_ff;     // dma mode select
   reg  [1:0]  thr_code_ff;     // rx_fill_threshold code
   reg  [10:0] rx_mem [0:15];   // data plus break, frame, parity
   reg  [7:0]  tx_mem [0:15];   // transmit characters
   reg  [3:0]  rx_wp_ff;        // rx write pointer
   reg  [3:0]  rx_rp_ff;        // rx read pointer
   reg  [4:0]  rx_cnt_ff;       // rx fill counter
   reg  [3:0]  tx_wp_ff;        // tx write pointer
   reg  [3:0]  tx_rp_ff;        // tx read pointer
   reg  [4:0]  tx_cnt_ff;       // tx fill counter
   reg  [4:0]  err_cnt_ff;      // entries held with an error
   reg         overrun_ff;      // sticky overrun
   reg         lstat_pend_ff;   // line status event pending
   reg         tout_ff;         // receive timeout seen
   reg         rx_dma_act_ff;   // mode1 rx ready latch
   reg  [7:0]  snap_ff;         // line state as captured in setup

   // ***************************************************
   // decode
   // ***************************************************
   wire        setup    = psel & ~penable;
   wire        access   = psel & penable;
   wire        wr       = access & pwrite;
   wire        rd       = access & ~pwrite;
   wire        hit_data = (paddr == `UFIRD_OFS_DATA);
   wire        hit_im   = (paddr == `UFIRD_OFS_IMASK);
   wire        hit_fc   = (paddr == `UFIRD_OFS_FCTRL);
   wire        hit_ic   = (paddr == `UFIRD_OFS_CAUSE);
   wire        hit_ls   = (paddr == `UFIRD_OFS_LSTATE);
   wire        mapped   = hit_data | hit_im | hit_fc | hit_ic | hit_ls;
   wire [4:0]  cap      = fifo_en_ff ? `UFIRD_DEPTH : 5'h01;  // one slot: holding reg
   wire [4:0]  tx_holding_reg      = fifo_en_ff ? thr_bytes(thr_code_ff) : 5'h01;
   wire        dma1     = fifo_en_ff & dma_mode_ff;

   // zero-wait slave; unmapped addresses error but still complete
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // ***************************************************
   // fifo movement
   // ***************************************************
   wire        fc_wr    = wr & hit_fc & pwdata[`UFIRD_FC_ENABLE];
   wire        fc_off   = wr & hit_fc & ~pwdata[`UFIRD_FC_ENABLE];
   wire        en_chg   = (fc_wr & ~fifo_en_ff) | (fc_off & fifo_en_ff);
   wire        rx_clr   = en_chg | (fc_wr & pwdata[`UFIRD_FC_RXRST]);
   wire        tx_clr   = en_chg | (fc_wr & pwdata[`UFIRD_FC_TXRST]);
   wire        rx_pop   = rd & hit_data & (rx_cnt_ff != 5'h00);
   wire        rx_push  = rx_char_valid & ((rx_cnt_ff < cap) | rx_pop);
   wire        rx_lost  = rx_char_valid & ~rx_push;
   wire        tx_push  = wr & hit_data & (tx_cnt_ff < cap);
   wire        tx_pop   = tx_char_valid & tx_char_ready;
   wire [10:0] rx_head  = rx_mem[rx_rp_ff];
   wire        in_err   = rx_char_parity_err | rx_char_frame_err | rx_char_break;
   wire        head_err = |rx_head[10:8];

   assign tx_char_valid = (tx_cnt_ff != 5'h00);
   assign tx_char_data  = tx_mem[tx_rp_ff];

   // ***************************************************
   // status terms
   // ***************************************************
   wire        rx_lvl   = (rx_cnt_ff >= tx_holding_reg);
   wire        tx_irq_c = dma1 ? (tx_cnt_ff < `UFIRD_DEPTH)
                               : (tx_cnt_ff == 5'h00);
   wire [7:0]  lstate;
   // break, frame and parity bits describe the character at the head of the fifo
   assign lstate[`UFIRD_LS_DREADY]     = (rx_cnt_ff != 5'h00);
   assign lstate[`UFIRD_LS_OVERRUN]    = overrun_ff;
   assign lstate[4:2]                  = lstate[0] ? rx_head[10:8] : 3'h0;
   assign lstate[`UFIRD_LS_TXFEMPTY]   = (tx_cnt_ff == 5'h00);
   assign lstate[`UFIRD_LS_TXALLEMPTY] = (tx_cnt_ff == 5'h00) & ~tx_shift_busy;
   assign lstate[`UFIRD_LS_FIFOERR]    = fifo_en_ff & (err_cnt_ff != 5'h00);

   // masked sources; all masks clear gives pure polled mode
   wire        src_ls   = imask_ff[`UFIRD_IM_LSTAT] & lstat_pend_ff;
   wire        src_rx   = imask_ff[`UFIRD_IM_RX_DMA_REQUEST_N] & rx_lvl;
   wire        src_to   = imask_ff[`UFIRD_IM_RX_DMA_REQUEST_N] & tout_ff & lstate[0];
   wire        src_tx   = imask_ff[`UFIRD_IM_TXEMPTY] & tx_irq_c;
   reg  [7:0]  cause;

   // priority encode of the pending cause
   always @*
   begin
      if (src_ls)
         cause = `UFIRD_IC_LSTAT;
      else if (src_rx)
         cause = `UFIRD_IC_RXDATA;      // cleared with the fill drop
      else if (src_to)
         cause = `UFIRD_IC_RXTOUT;
      else if (src_tx)
         cause = `UFIRD_IC_TXEMPTY;
      else
         cause = `UFIRD_IC_NONE;
   end

   // ***************************************************
   // control registers
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         imask_ff    <= `UFIRD_IMASK_RST;
         fifo_en_ff  <= 1'b0;
         dma_mode_ff <= 1'b0;
         thr_code_ff <= `UFIRD_THR_RST;
      end
      else
      begin
         if (wr & hit_im)
            imask_ff <= pwdata[3:0];
         // enable low: fifos off, the rest of the write is dropped
         if (fc_off)
            fifo_en_ff <= 1'b0;
         else if (fc_wr)
         begin
            fifo_en_ff  <= 1'b1;
            dma_mode_ff <= pwdata[`UFIRD_FC_DMAMODE];
            thr_code_ff <= pwdata[`UFIRD_FC_THR_HI:`UFIRD_FC_THR_LO];
         end
      end
   end

   // ***************************************************
   // storage arrays, no reset needed
   // ***************************************************
   always @(posedge pclk)
   begin
      if (rx_push & ~rx_clr)
         rx_mem[rx_wp_ff] <= {rx_char_break, rx_char_frame_err,
                              rx_char_parity_err, rx_char_data};
      if (tx_push & ~tx_clr)
         tx_mem[tx_wp_ff] <= pwdata[7:0];
   end

   // ***************************************************
   // receive pointers, counters and flags
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_wp_ff   <= 4'h0;
         rx_rp_ff   <= 4'h0;
         rx_cnt_ff  <= 5'h00;
         err_cnt_ff <= 5'h00;
      end
      else if (rx_clr)
      begin
         rx_wp_ff   <= 4'h0;
         rx_rp_ff   <= 4'h0;
         rx_cnt_ff  <= 5'h00;
         err_cnt_ff <= 5'h00;
      end
      else
      begin
         if (rx_push)
            rx_wp_ff <= ptr_inc(rx_wp_ff, fifo_en_ff);
         if (rx_pop)
            rx_rp_ff <= ptr_inc(rx_rp_ff, fifo_en_ff);
         // registered fill counter feeds every comparison
         rx_cnt_ff  <= rx_cnt_ff + {4'h0, rx_push} - {4'h0, rx_pop};
         err_cnt_ff <= err_cnt_ff + {4'h0, rx_push & in_err}
                                  - {4'h0, rx_pop & head_err};
      end
   end

   // sticky flags; a new event beats a clear in the same cycle, except for the mode1 latch, where rx_clr or leaving mode1 wins
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         overrun_ff    <= 1'b0;
         lstat_pend_ff <= 1'b0;
         tout_ff       <= 1'b0;
         rx_dma_act_ff <= 1'b0;
      end
      else
      begin
         // overrun clears only if the read reported it; any line state read clears lstat_pend_ff
         overrun_ff    <= rx_lost |
                          (overrun_ff & ~(rd & hit_ls & snap_ff[`UFIRD_LS_OVERRUN]));
         lstat_pend_ff <= rx_push | (lstat_pend_ff & ~(rd & hit_ls));
         tout_ff       <= rx_timeout | (tout_ff & ~rx_pop & ~rx_clr);
         // mode1 latch: armed by threshold or timeout, dropped on empty
         if (~dma1 | rx_clr)
            rx_dma_act_ff <= 1'b0;
         else if (rx_lvl | rx_timeout)
            rx_dma_act_ff <= 1'b1;
         else if (rx_cnt_ff == 5'h00)
            rx_dma_act_ff <= 1'b0;
      end
   end

   // ***************************************************
   // transmit pointers and counter
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_wp_ff  <= 4'h0;
         tx_rp_ff  <= 4'h0;
         tx_cnt_ff <= 5'h00;
      end
      else if (tx_clr)
      begin
         tx_wp_ff  <= 4'h0;
         tx_rp_ff  <= 4'h0;
         tx_cnt_ff <= 5'h00;
      end
      else
      begin
         if (tx_push)
            tx_wp_ff <= ptr_inc(tx_wp_ff, fifo_en_ff);
         if (tx_pop)
            tx_rp_ff <= ptr_inc(tx_rp_ff, fifo_en_ff);
         tx_cnt_ff <= tx_cnt_ff + {4'h0, tx_push} - {4'h0, tx_pop};
      end
   end

   // ***************************************************
   // pins: interrupt and dma ready, one cycle behind the counters
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_ff           <= 1'b0;
         tx_dma_request_n <= 1'b0;          // reset leaves tx empty
         rx_dma_request_n <= 1'b1;
      end
      else
      begin
         irq_ff <= src_ls | src_rx | src_to | src_tx;
         if (dma1)
         begin
            tx_dma_request_n <= (tx_cnt_ff == `UFIRD_DEPTH);
            // level term as well as the latch keeps the pin one cycle behind
            rx_dma_request_n <= ~((rx_dma_act_ff | rx_lvl) & (rx_cnt_ff != 5'h00));
         end
         else
         begin
            tx_dma_request_n <= (tx_cnt_ff != 5'h00);
            rx_dma_request_n <= (rx_cnt_ff == 5'h00);
         end
      end
   end

   // ***************************************************
   // read data, captured in the setup phase
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         snap_ff <= 8'h00;
      end
      else if (setup & ~pwrite)
      begin
         snap_ff <= lstate;
         // control register is write-only and reads zero
         if (hit_data)
            prdata <= {24'h000000, rx_head[7:0]};
         else if (hit_im)
            prdata <= {28'h0000000, imask_ff};
         else if (hit_ic)
            prdata <= {24'h000000, cause};
         else if (hit_ls)
            prdata <= {24'h000000, lstate};
         else
            prdata <= 32'h00000000;
      end
   end

endmodule

// >>> tb/ufird_host.sv
// apb host model driving the register port of ufird_core
`timescale 1ns/1ns
module ufird_host
(
   // clock
   input  wire        pclk,
   // apb request
   output reg         psel,
   output reg         penable,
   output reg         pwrite,
   output reg  [7:0]  paddr,
   output reg  [31:0] pwdata,
   // apb answer
   input  wire [31:0] prdata,
   input  wire        pready,
   input  wire        pslverr
);
   // **********
   // transfers
   // **********
   // bus idle from time zero
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'hFF;
      pwdata  = 32'h0;
   end
   // setup, then access held until pready is seen at an edge
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] rd, output err);
   begin
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released bus must not keep showing the old request
      paddr   <= ~a;
      pwdata  <= ~d;
   end
   endtask
endmodule

// >>> tb/ufird_core_assertions.sv
// port checker bound into ufird_core
`timescale 1ns/1ns
`include "ufird_consts.vh"
module ufird_chk
(
   // apb side
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   // character side
   input wire        rx_char_valid,
   input wire        rx_timeout,
   input wire        tx_char_valid,
   input wire [7:0]  tx_char_data,
   input wire        tx_char_ready,
   // pins
   input wire        irq_ff,
   input wire        tx_dma_request_n,
   input wire        rx_dma_request_n
);
   // **********
   // shadows
   // **********
   wire       acc   = psel && penable && pready;                   // access edge
   wire       fc_wr = acc && pwrite && paddr == `UFIRD_OFS_FCTRL;  // control write
   wire       pop   = acc && !pwrite && paddr == `UFIRD_OFS_DATA;  // rx pop
   reg  [3:0] mask_ff;                                             // mask copy
   reg        mode1_ff;                                            // block mode
   // mode 1 with fifos off behaves as mode 0, so it is never shadowed
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_ff  <= 4'h0;
         mode1_ff <= 1'b0;
      end
      else
      begin
         if (acc && pwrite && paddr == `UFIRD_OFS_IMASK)
            mask_ff <= pwdata[3:0];
         if (fc_wr)
            mode1_ff <= pwdata[0] & pwdata[3];
      end
   end
   // **********
   // properties
   // **********
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_irq_all_masked: assert property (mask_ff[2:0] == 3'h0 [*2] |-> !irq_ff)
      else $error("irq high with every source masked");
   a_lstat_irq: assert property
      (mask_ff == 4'h4 && rx_char_valid ##1 mask_ff == 4'h4 |-> ##1 irq_ff)
      else $error("no line status irq after a received char");
   a_tx_irq_mode0: assert property
      ((mask_ff == 4'h2 && !mode1_ff) [*2] |-> irq_ff == !$past(tx_char_valid))
      else $error("tx irq does not follow tx empty");
   a_txpin_mode0: assert property
      (!mode1_ff [*2] |-> tx_dma_request_n == $past(tx_char_valid))
      else $error("tx ready pin wrong in mode 0");
   a_txpin_held: assert property (tx_dma_request_n |-> $past(tx_char_valid))
      else $error("tx ready pin high with tx fifo empty");
   a_tx_head_hold: assert property
      (tx_char_valid && !tx_char_ready && !(psel && pwrite) |=>
       tx_char_valid && $stable(tx_char_data))
      else $error("tx head moved without a pop");
   a_rxpin_release: assert property
      ($rose(rx_dma_request_n) |-> $past(pop, 2) || $past(fc_wr, 2))
      else $error("rx ready pin released without a pop");
   a_rxpin_request: assert property
      ($fell(rx_dma_request_n) |->
       $past(rx_char_valid, 2) || $past(rx_timeout, 2) || $past(fc_wr, 2))
      else $error("rx ready pin active without a char");
endmodule
bind ufird_core ufird_chk ufird_chk_i
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .rx_char_valid, .rx_timeout, .tx_char_valid, .tx_char_data, .tx_char_ready,
   .irq_ff, .tx_dma_request_n, .rx_dma_request_n
);

// >>> tb/uart_fifo_irq_dma_ready_bench.sv
// self-checking bench for the uart fifo, interrupt and dma ready block
`timescale 1ns/1ns
`include "ufird_consts.vh"
module uart_fifo_irq_dma_ready_bench;
   // **********
   // signals
   // **********
   reg         pclk;               // 25 MHz
   reg         presetn;            // async, low active
   reg         rx_char_valid;      // rx char strobe
   reg  [7:0]  rx_char_data;       // rx char
   reg         rx_char_parity_err; // rx char parity flag
   reg         rx_char_frame_err;  // rx char framing flag
   reg         rx_char_break;      // rx char break flag
   reg         rx_timeout;         // rx timeout event
   reg         tx_char_ready;      // tx shifter takes a char
   reg         tx_shift_busy;      // tx shifter holds a char
   wire        psel, penable, pwrite, pready, pslverr;
   wire [7:0]  paddr;
   wire [31:0] pwdata;
   wire [31:0] prdata;
   wire        tx_char_valid, irq_ff, tx_dma_request_n, rx_dma_request_n;
   wire [7:0]  tx_char_data;
   reg  [31:0] v;                  // last read data
   reg         er;                 // last error answer
   integer     fails;
   integer     comparisons;
   integer     i;
   integer     j;
   // row: control byte, chars pushed, expected irq, cause, rx pin
   typedef struct packed {logic [7:0] fc; logic [4:0] n; logic irq;
                          logic [7:0] cause; logic rxn;} ufird_row_t;
   ufird_row_t rows [0:9];
   ufird_core ufird_core_i
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_char_valid, .rx_char_data, .rx_char_parity_err,
      .rx_char_frame_err, .rx_char_break, .rx_timeout, .tx_char_valid,
      .tx_char_data, .tx_char_ready, .tx_shift_busy, .irq_ff, .tx_dma_request_n,
      .rx_dma_request_n
   );
   ufird_host ufird_host_i
   (
      .pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
   );
   // **********
   // tasks
   // **********
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
   begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      ufird_host_i.xfer(1'b1, a, d, v, er);
   endtask
   task rd(input [7:0] a);
      ufird_host_i.xfer(1'b0, a, 32'h0, v, er);
   endtask
   // one-cycle receive strobe, data scrambled afterwards
   task push(input [7:0] d, input [2:0] ev);
   begin
      @(posedge pclk);
      rx_char_valid      <= 1'b1;
      rx_char_data       <= d;
      rx_char_parity_err <= ev[0];
      rx_char_frame_err  <= ev[1];
      rx_char_break      <= ev[2];
      @(posedge pclk);
      rx_char_valid      <= 1'b0;
      rx_char_data       <= ~d;
   end
   endtask
   task report_and_stop;
   begin
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // **********
   // clock, watchdog, sequence
   // **********
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // whole run needs about 400 cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      fails = fails + 1;
      report_and_stop;
   end
   initial
   begin
      presetn            = 1'b0;
      rx_char_valid      = 1'b0;
      rx_char_data       = 8'h00;
      rx_char_parity_err = 1'b0;
      rx_char_frame_err  = 1'b0;
      rx_char_break      = 1'b0;
      rx_timeout         = 1'b0;
      tx_char_ready      = 1'b0;
      tx_shift_busy      = 1'b0;
      fails              = 0;
      comparisons        = 0;
      rows[0] = '{8'h01, 5'h00, 1'b0, 8'h01, 1'b1};
      rows[1] = '{8'h01, 5'h01, 1'b1, 8'h04, 1'b0};
      rows[2] = '{8'h41, 5'h03, 1'b0, 8'h01, 1'b0};
      rows[3] = '{8'h41, 5'h04, 1'b1, 8'h04, 1'b0};
      rows[4] = '{8'h81, 5'h07, 1'b0, 8'h01, 1'b0};
      rows[5] = '{8'h81, 5'h08, 1'b1, 8'h04, 1'b0};
      rows[6] = '{8'hC1, 5'h0D, 1'b0, 8'h01, 1'b0};
      rows[7] = '{8'hC1, 5'h0E, 1'b1, 8'h04, 1'b0};
      rows[8] = '{8'h49, 5'h03, 1'b0, 8'h01, 1'b1};
      rows[9] = '{8'h49, 5'h04, 1'b1, 8'h04, 1'b0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`UFIRD_OFS_IMASK);
      chk("imask", v, 32'h0);
      rd(`UFIRD_OFS_LSTATE);
      chk("lstate", v, 32'h60);
      chk("tx_n", tx_dma_request_n, 1'b0);
      rd(8'h20);
      chk("slverr", er, 1'b1);
      // threshold codes and both dma modes, fifos cleared per row
      for (i = 0; i < 10; i = i + 1)
      begin
         wr(`UFIRD_OFS_FCTRL, {24'h0, rows[i].fc | 8'h06});
         wr(`UFIRD_OFS_IMASK, 32'h01);
         for (j = 0; j < rows[i].n; j = j + 1)
            push({i[3:0], j[3:0]}, 3'h0);
         repeat (3) @(posedge pclk);
         rd(`UFIRD_OFS_CAUSE);
         chk("cause", v, rows[i].cause);
         chk("irq", irq_ff, rows[i].irq);
         chk("rx_n", rx_dma_request_n, rows[i].rxn);
      end
      // mode 1 pin stays active below threshold until the fifo drains
      rd(`UFIRD_OFS_DATA);
      chk("rx data", v, 32'h90);
      repeat (2) @(posedge pclk);
      chk("irq", irq_ff, 1'b0);
      chk("rx_n", rx_dma_request_n, 1'b0);
      repeat (3) rd(`UFIRD_OFS_DATA);
      repeat (2) @(posedge pclk);
      chk("rx_n", rx_dma_request_n, 1'b1);
      rd(`UFIRD_OFS_LSTATE);
      chk("dready", v[0], 1'b0);
      push(8'h3C, 3'h0);
      rx_timeout <= 1'b1;
      @(posedge pclk);
      rx_timeout <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("rx_n", rx_dma_request_n, 1'b0);
      // mode 1 transmit: fill to full, one extra dropped, drain in order
      wr(`UFIRD_OFS_FCTRL, 32'h0F);
      wr(`UFIRD_OFS_IMASK, 32'h02);
      for (j = 0; j < 17; j = j + 1)
         wr(`UFIRD_OFS_DATA, j);
      repeat (2) @(posedge pclk);
      chk("tx_n", tx_dma_request_n, 1'b1);
      chk("irq", irq_ff, 1'b0);
      rd(`UFIRD_OFS_LSTATE);
      chk("tx empty", v[6:5], 2'h0);
      tx_char_ready <= 1'b1;
      for (j = 0; j < 16; j = j + 1)
      begin
         @(negedge pclk);
         chk("tx head", tx_char_data, j);
      end
      @(negedge pclk);
      chk("tx valid", tx_char_valid, 1'b0);
      @(posedge pclk);
      tx_char_ready <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("irq", irq_ff, 1'b1);
      chk("tx_n", tx_dma_request_n, 1'b0);
      // mode 0 transmit and shifter busy
      wr(`UFIRD_OFS_FCTRL, 32'h07);
      repeat (2) @(posedge pclk);
      chk("irq", irq_ff, 1'b1);
      wr(`UFIRD_OFS_DATA, 32'h5A);
      repeat (2) @(posedge pclk);
      chk("tx_n", tx_dma_request_n, 1'b1);
      chk("irq", irq_ff, 1'b0);
      tx_shift_busy <= 1'b1;
      tx_char_ready <= 1'b1;
      @(posedge pclk);
      tx_char_ready <= 1'b0;
      rd(`UFIRD_OFS_LSTATE);
      chk("tx empty", v[6:5], 2'h1);
      tx_shift_busy <= 1'b0;
      rd(`UFIRD_OFS_LSTATE);
      chk("tx empty", v[6:5], 2'h3);
      // errored char raises line status, reading line state clears it
      wr(`UFIRD_OFS_IMASK, 32'h04);
      push(8'h11, 3'h5);
      repeat (2) @(posedge pclk);
      chk("irq", irq_ff, 1'b1);
      rd(`UFIRD_OFS_CAUSE);
      chk("cause", v, 32'h06);
      rd(`UFIRD_OFS_LSTATE);
      chk("lstate", v, 32'hF5);
      repeat (2) @(posedge pclk);
      chk("irq", irq_ff, 1'b0);
      // fifos off holds one char, second overruns, polled with no irq
      wr(`UFIRD_OFS_FCTRL, 32'h08);
      wr(`UFIRD_OFS_IMASK, 32'h00);
      push(8'h21, 3'h0);
      push(8'h22, 3'h0);
      repeat (2) @(posedge pclk);
      chk("irq", irq_ff, 1'b0);
      chk("rx_n", rx_dma_request_n, 1'b0);
      rd(`UFIRD_OFS_LSTATE);
      chk("lstate", v, 32'h63);
      rd(`UFIRD_OFS_DATA);
      chk("rx data", v, 32'h21);
      report_and_stop;
   end
endmodule
